// ==== hw/crma_pkg.sv ====
package crma_pkg;

	// ----------------------------------------
	// Tokens
	// ----------------------------------------
	localparam logic [7:0] CRMA_TOK_WRITE  = 8'hc0;
	localparam logic [7:0] CRMA_TOK_READ   = 8'hc1;
	localparam logic [7:0] CRMA_TOK_PREAD  = 8'h25;
	localparam logic [7:0] CRMA_TOK_END    = 8'h01;
	localparam logic [7:0] CRMA_TOK_ACK    = 8'h03;
	localparam logic [7:0] CRMA_TOK_NACK   = 8'h04;
	localparam logic [7:0] CRMA_NOREPLY    = 8'hff;

	// ----------------------------------------
	// Field lengths, in bytes minus one; word size and max size in whole bytes
	// ----------------------------------------
	localparam logic [1:0] CRMA_RID_LAST   = 2'h2;
	localparam logic [1:0] CRMA_REG_LAST   = 2'h1;
	localparam logic [1:0] CRMA_PREG_LAST  = 2'h0;
	localparam logic [1:0] CRMA_DATA_LAST  = 2'h3;
	localparam logic [2:0] CRMA_WORD_BYTES = 3'h4;
	localparam logic [7:0] CRMA_MAX_SIZE   = 8'h04;

	// ----------------------------------------
	// Reply buffer
	// ----------------------------------------
	localparam int         CRMA_BUF_W      = 33;
	localparam logic [1:0] CRMA_BUF_DEPTH  = 2'h2;

	typedef enum logic [6:0] {
		CRMA_IDLE  = 7'h01,
		CRMA_RID   = 7'h02,
		CRMA_REG   = 7'h04,
		CRMA_DATA  = 7'h08,
		CRMA_SIZE  = 7'h10,
		CRMA_END   = 7'h20,
		CRMA_REPLY = 7'h40
	} crma_state_t;

endpackage : crma_pkg

// ==== hw/crma_responder.sv ====
`timescale 1ns/10ps
module crma_responder (
	// Clock and reset
	input  wire logic                   ref_clk,
	input  wire logic                   nrst,
	// Request token stream
	input  wire logic                   inValid,
	output logic                        inReady,
	input  wire logic                   inCtl,
	input  wire logic [7:0]             inByte,
	// Reply token stream
	output logic                        outValid,
	input  wire logic                   outReady,
	output logic                        outCtl,
	output logic [7:0]                  outByte,
	output logic [23:0]                 outDest,
	// Register store access
	output logic                        regReq,
	output logic                        regWrite,
	output logic                        regPeriph,
	output logic [15:0]                 regAddr,
	output logic [31:0]                 regWdata,
	output logic [7:0]                  regSize,
	input  wire logic                   regAck,
	input  wire logic                   regErr,
	input  wire logic [31:0]            regRdata
);
	import crma_pkg::*;

	// ----------------------------------------
	// Request parser
	// ----------------------------------------
	crma_state_t       state_q;
	logic [1:0]        cnt_q;
	logic              isWr_q;
	logic              isRd_q;
	logic              isPr_q;
	logic              bad_q;
	logic [23:0]       rid_q;
	logic              take;
	logic              endTok;
	logic [1:0]        regLast;
	logic              sizeBad;

	assign inReady = (state_q != CRMA_REPLY) && !regReq;
	assign take    = inValid && inReady;
	assign endTok  = inCtl && (inByte == CRMA_TOK_END);
	assign regLast = isPr_q ? CRMA_PREG_LAST : CRMA_REG_LAST;
	assign sizeBad = isPr_q && ((regSize == 8'h00) || (regSize > CRMA_MAX_SIZE));

	// Reply sequencing
	logic              pushValid;
	logic              pushReady;
	logic              pushCtl;
	logic [7:0]        pushByte;
	logic [1:0]        phase_q;
	logic [2:0]        left_q;
	logic              fail_q;
	logic [31:0]       rdata_q;
	logic              suppress;
	logic              started_q;

	assign suppress = isWr_q && !fail_q && (rid_q[7:0] == CRMA_NOREPLY);

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			state_q <= CRMA_IDLE;
			cnt_q   <= 2'h0;
			isWr_q  <= 1'b0;
			isRd_q  <= 1'b0;
			isPr_q  <= 1'b0;
			bad_q   <= 1'b0;
			rid_q   <= 24'h000000;
			regAddr <= 16'h0000;
			regWdata <= 32'h00000000;
			regSize <= 8'h00;
		end else begin
			case (state_q)
				CRMA_IDLE: begin
					if (take && inCtl) begin
						isWr_q  <= (inByte == CRMA_TOK_WRITE);
						isRd_q  <= (inByte == CRMA_TOK_READ);
						isPr_q  <= (inByte == CRMA_TOK_PREAD);
						bad_q   <= !((inByte == CRMA_TOK_WRITE) || (inByte == CRMA_TOK_READ)
							|| (inByte == CRMA_TOK_PREAD));
						cnt_q   <= 2'h0;
						regAddr <= 16'h0000;
						state_q <= CRMA_RID;
					end
				end
				CRMA_RID, CRMA_REG, CRMA_DATA, CRMA_SIZE: begin
					if (take && inCtl) begin
						bad_q <= 1'b1;
						if (endTok) begin
							state_q <= CRMA_REPLY;
						end
					end else if (take) begin
						cnt_q <= cnt_q + 2'h1;
						if (state_q == CRMA_RID) begin
							rid_q <= {rid_q[15:0], inByte};
							if (cnt_q == CRMA_RID_LAST) begin
								cnt_q   <= 2'h0;
								state_q <= CRMA_REG;
							end
						end else if (state_q == CRMA_REG) begin
							regAddr <= {regAddr[7:0], inByte};
							if (cnt_q == regLast) begin
								cnt_q   <= 2'h0;
								state_q <= isWr_q ? CRMA_DATA : (isPr_q ? CRMA_SIZE : CRMA_END);
							end
						end else if (state_q == CRMA_DATA) begin
							regWdata <= {regWdata[23:0], inByte};
							if (cnt_q == CRMA_DATA_LAST) begin
								state_q <= CRMA_END;
							end
						end else begin
							regSize <= inByte;
							state_q <= CRMA_END;
						end
					end
				end
				CRMA_END: begin
					if (take && endTok) begin
						state_q <= CRMA_REPLY;
					end else if (take) begin
						bad_q <= 1'b1;
					end
				end
				CRMA_REPLY: begin
					// Wait for the access to start, so a stale fail_q cannot end it
					if (started_q && !regReq && (phase_q == 2'h3 || suppress) && pushReady) begin
						state_q <= CRMA_IDLE;
					end
				end
				default: state_q <= CRMA_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Register store access
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			regReq    <= 1'b0;
			started_q <= 1'b0;
			fail_q    <= 1'b0;
			rdata_q   <= 32'h00000000;
			left_q    <= 3'h0;
		end else if (state_q != CRMA_REPLY) begin
			started_q <= 1'b0;
		end else if (!started_q) begin
			started_q <= 1'b1;
			fail_q    <= bad_q || sizeBad;
			regReq    <= !(bad_q || sizeBad);
			left_q    <= 3'h0;
		end else if (regReq && regAck) begin
			regReq  <= 1'b0;
			fail_q  <= regErr;
			left_q  <= regErr ? 3'h0 : (isPr_q ? regSize[2:0] : (isRd_q ? CRMA_WORD_BYTES : 3'h0));
			rdata_q <= isPr_q ? (regRdata << {(CRMA_WORD_BYTES - regSize[2:0]), 3'h0})
				: regRdata;
		end else if (pushValid && pushReady && phase_q == 2'h1) begin
			left_q  <= left_q - 3'h1;
			rdata_q <= {rdata_q[23:0], 8'h00};
		end
	end

	assign regWrite  = isWr_q;
	assign regPeriph = isPr_q;

	// ----------------------------------------
	// Reply emission: head, data, end
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			phase_q <= 2'h0;
		end else if (state_q != CRMA_REPLY || !started_q) begin
			phase_q <= 2'h0;
		end else if (pushValid && pushReady) begin
			if (phase_q == 2'h0) begin
				phase_q <= (left_q == 3'h0) ? 2'h2 : 2'h1;
			end else if (phase_q == 2'h1) begin
				phase_q <= (left_q == 3'h1) ? 2'h2 : 2'h1;
			end else begin
				phase_q <= 2'h3;
			end
		end
	end

	always_comb begin
		pushValid = started_q && !regReq && !suppress && (phase_q != 2'h3)
			&& (state_q == CRMA_REPLY);
		pushCtl   = (phase_q != 2'h1);
		case (phase_q)
			2'h0:    pushByte = fail_q ? CRMA_TOK_NACK : CRMA_TOK_ACK;
			2'h1:    pushByte = rdata_q[31:24];
			default: pushByte = CRMA_TOK_END;
		endcase
	end

	// ----------------------------------------
	// Two-entry reply buffer
	// ----------------------------------------
	logic [CRMA_BUF_W-1:0] mem_q [2];
	logic                  wp_q;
	logic                  rp_q;
	logic [1:0]            fill_q;
	logic                  doPush;
	logic                  doPop;

	assign pushReady = (fill_q != CRMA_BUF_DEPTH);
	assign doPush    = pushValid && pushReady;
	assign outValid  = (fill_q != 2'h0);
	assign doPop     = outValid && outReady;
	assign {outDest, outCtl, outByte} = mem_q[rp_q];

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			wp_q   <= 1'b0;
			rp_q   <= 1'b0;
			fill_q <= 2'h0;
		end else begin
			if (doPush) begin
				wp_q <= !wp_q;
			end
			if (doPop) begin
				rp_q <= !rp_q;
			end
			fill_q <= fill_q + {1'b0, doPush} - {1'b0, doPop};
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : gEntry
			always_ff @(posedge ref_clk) begin
				if (!nrst) begin
					mem_q[gi] <= '0;
				end else if (doPush && (wp_q == 1'(gi))) begin
					mem_q[gi] <= {rid_q, pushCtl, pushByte};
				end
			end
		end
	endgenerate

endmodule : crma_responder

// ==== tb/crma_properties.sv ====
`timescale 1ns/10ps
module crma_properties (
	input wire logic        ref_clk, nrst, inReady, outValid, outReady, outCtl,
	input wire logic        regReq, regWrite, regPeriph, regAck, regErr,
	input wire logic [7:0]  outByte, regSize,
	input wire logic [15:0] regAddr
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	sequence s_done;
		regReq && regAck;
	endsequence
	sequence s_head(logic [7:0] b);
		outValid && outCtl && outByte == b;
	endsequence
	a_req_holds: assert property (regReq && !regAck |=> regReq && $stable(regAddr))
		else $error("access request dropped early");
	a_reply_holds: assert property (outValid && !outReady |=> outValid && $stable(outByte))
		else $error("reply beat changed while stalled");
	a_reply_blocks: assert property (regReq |-> !inReady)
		else $error("request taken during access");
	a_ack_releases: assert property (s_done |=> !regReq)
		else $error("access request held after ack");
	a_nack_err: assert property (s_done ##0 regErr ##1 !outValid |=> s_head(8'h04))
		else $error("failed access gave no nack");
	a_read_ack: assert property (s_done ##0 (!regErr && !regWrite) ##1 !outValid |=> s_head(8'h03))
		else $error("read gave no ack");
	a_write_ack: assert property (s_done ##0 (!regErr && regWrite) ##1 !outValid
		|=> (!outValid or s_head(8'h03)))
		else $error("write reply wrong");
	a_size_legal: assert property (regReq && regPeriph |-> regSize != 8'h00
		&& regSize <= crma_pkg::CRMA_MAX_SIZE)
		else $error("peripheral access with illegal size");
	a_nack_end: assert property (s_head(8'h04) ##0 outReady |=> s_head(8'h01))
		else $error("nack not closed by end token");
endmodule : crma_properties

// ==== tb/crma_store.sv ====
`timescale 1ns/10ps
module crma_store (
	input wire logic        ref_clk, nrst, regReq, regWrite,
	input wire logic [15:0] regAddr,
	input wire logic [31:0] regWdata,
	output logic            regAck = 1'b0,
	output logic            regErr = 1'b0,
	output logic [31:0]     regRdata = 32'h0
);
	logic [31:0] mem [16];
	logic [1:0]  waitQ;
	always_ff @(posedge ref_clk) begin
		regAck <= 1'b0;
		regRdata <= ~regRdata;
		if (!nrst) begin
			waitQ <= 2'h0;
		end else if (regReq && !regAck) begin
			if (waitQ != 2'h0) begin
				waitQ <= waitQ - 2'h1;
			end else begin
				regAck <= 1'b1;
				regErr <= |regAddr[15:4];
				regRdata <= mem[regAddr[3:0]];
				if (regWrite && !(|regAddr[15:4])) mem[regAddr[3:0]] <= regWdata;
				waitQ <= 2'($urandom);
			end
		end
	end
endmodule : crma_store

// ==== tb/crma_responder_tb.sv ====
`timescale 1ns/10ps
module crma_responder_tb;
	import crma_pkg::*;
	logic ref_clk, nrst, inValid, inReady, inCtl, outValid, outReady, outCtl;
	logic regReq, regWrite, regAck, regErr;
	logic [7:0] inByte, outByte;
	logic [23:0] outDest;
	logic [15:0] regAddr;
	logic [31:0] regWdata, regRdata;
	logic [31:0] shadow [16];
	logic [32:0] exq [$];
	int miscompares = 0;
	int check_count = 0;
	// Requester addressing, kept by the requesting side
	localparam logic [7:0]  PS_RES_LOW  = 8'h0c;
	localparam logic [15:0] TILE_SUFFIX = 16'hc20c;
	localparam logic [15:0] NODE_SUFFIX = 16'hc30c;
	localparam logic [7:0]  PERIPH_LOW  = 8'h02;
	crma_responder dut_u (.ref_clk(ref_clk), .nrst(nrst), .inValid(inValid), .inReady(inReady),
		.inCtl(inCtl), .inByte(inByte), .outValid(outValid), .outReady(outReady),
		.outCtl(outCtl), .outByte(outByte), .outDest(outDest), .regReq(regReq),
		.regWrite(regWrite), .regPeriph(), .regAddr(regAddr), .regWdata(regWdata),
		.regSize(), .regAck(regAck), .regErr(regErr), .regRdata(regRdata));
	crma_store store_u (.ref_clk(ref_clk), .nrst(nrst), .regReq(regReq), .regWrite(regWrite),
		.regAddr(regAddr), .regWdata(regWdata), .regAck(regAck), .regErr(regErr),
		.regRdata(regRdata));
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(negedge ref_clk) outReady <= 1'($urandom);
	always @(posedge ref_clk) if (nrst && outValid && outReady) begin
		check_count++;
		if (exq.size() == 0 || exq[0] !== {outDest, outCtl, outByte}) begin
			miscompares++;
			$display("Error reply beat expected %h seen %h", exq[0], {outDest, outCtl, outByte});
		end
		if (exq.size() != 0) void'(exq.pop_front());
	end
	task automatic put(input logic c, input logic [7:0] b);
		inCtl = c;
		inByte = b;
		inValid = 1'b1;
		// Ready is steady between rising edges; beat taken at the next one
		while (!inReady) @(negedge ref_clk);
		@(negedge ref_clk);
	endtask : put
	task automatic run(input logic [7:0] cmd, input logic [23:0] rid, input logic [15:0] adr,
		input logic [31:0] dat, input logic [7:0] sz);
		logic ok, sup;
		logic [31:0] w;
		ok = (cmd == CRMA_TOK_PREAD) ? (sz != 8'h00 && sz <= CRMA_MAX_SIZE && adr[7:4] == 4'h0)
			: ((cmd == CRMA_TOK_WRITE || cmd == CRMA_TOK_READ) && adr[15:4] == 12'h000);
		sup = ok && cmd == CRMA_TOK_WRITE && rid[7:0] == CRMA_NOREPLY;
		w = shadow[adr[3:0]];
		if (ok && cmd == CRMA_TOK_WRITE) shadow[adr[3:0]] = dat;
		if (!sup) exq.push_back({rid, 1'b1, ok ? CRMA_TOK_ACK : CRMA_TOK_NACK});
		if (ok && cmd == CRMA_TOK_READ) for (int i = 3; i >= 0; i--) exq.push_back({rid, 1'b0, w[i*8 +: 8]});
		if (ok && cmd == CRMA_TOK_PREAD) for (int i = int'(sz) - 1; i >= 0; i--) exq.push_back({rid, 1'b0, w[i*8 +: 8]});
		if (!sup) exq.push_back({rid, 1'b1, CRMA_TOK_END});
		put(1'b1, cmd);
		for (int i = 2; i >= 0; i--) put(1'b0, rid[i*8 +: 8]);
		if (cmd == CRMA_TOK_PREAD) begin
			put(1'b0, adr[7:0]);
			put(1'b0, sz);
		end else begin
			put(1'b0, adr[15:8]);
			put(1'b0, adr[7:0]);
		end
		if (cmd == CRMA_TOK_WRITE) for (int i = 3; i >= 0; i--) put(1'b0, dat[i*8 +: 8]);
		put(1'b1, CRMA_TOK_END);
		inValid = 1'b0;
		@(negedge ref_clk);
	endtask : run
	task automatic summarize();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : summarize
	initial begin
		#100000;
		miscompares++;
		summarize();
	end
	initial begin
		logic [23:0] r;
		static logic [7:0] cmds [4] = '{CRMA_TOK_WRITE, CRMA_TOK_READ, CRMA_TOK_PREAD, 8'h55};
		void'($urandom(32'h5828));
		{nrst, inValid, inCtl, inByte, outReady} = '0;
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		nrst = 1'b1;
		for (int a = 0; a < 16; a++) run(CRMA_TOK_WRITE, 24'h0a0b00 + 24'(a), 16'(a), $urandom, 8'h0);
		run(CRMA_TOK_WRITE, 24'h1234ff, 16'h0003, 32'hdeadbeef, 8'h0);
		run(CRMA_TOK_WRITE, 24'h1234ff, 16'h0103, 32'h0, 8'h0);
		for (int s = 0; s < 6; s++) run(CRMA_TOK_PREAD, 24'h00c3a5, 16'h0003, 32'h0, 8'(s));
		// Early closing token: write cut after the return id
		exq.push_back({24'h00c3a5, 1'b1, CRMA_TOK_NACK});
		exq.push_back({24'h00c3a5, 1'b1, CRMA_TOK_END});
		put(1'b1, CRMA_TOK_WRITE);
		put(1'b0, 8'h00);
		put(1'b0, 8'hc3);
		put(1'b0, 8'ha5);
		put(1'b1, CRMA_TOK_END);
		inValid = 1'b0;
		@(negedge ref_clk);
		for (int n = 0; n < 40; n++) begin
			r = 24'($urandom);
			if (r[9:8] == 2'h0) r[7:0] = CRMA_NOREPLY;
			run(cmds[$urandom % 4], r, 16'($urandom % 20), $urandom, 8'($urandom % 6));
		end
		for (int i = 0; i < 2000 && exq.size() != 0; i++) @(posedge ref_clk);
		repeat (20) @(posedge ref_clk);
		if (exq.size() != 0) miscompares++;
		summarize();
	end
endmodule : crma_responder_tb
bind crma_responder crma_properties chk_u (.ref_clk(ref_clk), .nrst(nrst), .inReady(inReady),
	.outValid(outValid), .outReady(outReady), .outCtl(outCtl), .regReq(regReq),
	.regWrite(regWrite), .regPeriph(regPeriph), .regAck(regAck), .regErr(regErr),
	.outByte(outByte), .regSize(regSize), .regAddr(regAddr));
